/* hilo_multiply_move_unit.sv */
// Product register pair, signed word multiply and conditional moves.
// Assumes the pipeline end supplies operand values and checks issue spacing.
`timescale 1ns/1ps

// Summary of operation
// - Copy top word to destination register
// - Copy bottom word to destination register
// - No top writers two slots after copy
// - No bottom writers two slots after copy
// - Move first source if second nonzero
// - Move first source if second zero
// - Load top word from first source
// - Load bottom word from first source
// - No copy-from-top two before load-top
// - No copy-from-bottom two before load-bottom
// - Load-top over unread result spoils bottom
// - Load-bottom over unread result spoils top
// - Signed 32x32 multiply, 64-bit product
// - Low half bottom, high half top
// - Multiply never raises any exception
// - Multiply operands must be sign-extended words
// - No copies two slots before multiply
// - Multi-cycle multiply; product reads stall
module hilo_multiply_move_unit #(
   parameter int unsigned DATA_W     = hilo_pkg::WORD_W,
   parameter int unsigned MUL_CYCLES = hilo_pkg::MUL_CYCLES
) (
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   hilo_link_if.unit              link,
   output logic [DATA_W-1:0]      top_word_out,
   output logic [DATA_W-1:0]      bottom_word_out,
   output logic                   busy_out,
   output logic                   result_unread_out
);

   localparam int unsigned CNT_W = (MUL_CYCLES > 1) ? $clog2(MUL_CYCLES) : 1;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MUL_CYCLES - 1);
   localparam int unsigned PROD_W = 2 * hilo_pkg::WORD_W;

   typedef enum logic [0:0] {
      mul_idle,
      mul_run
   } mul_state_type;

   // Widen a 32-bit word to register width by copying bit 31
   function automatic logic [DATA_W-1:0] sext_word(input logic [hilo_pkg::WORD_W-1:0] w);
      for (int i = 0; i < DATA_W; i++) begin
         if (i < hilo_pkg::WORD_W)
            sext_word[i] = w[i];
         else
            sext_word[i] = w[hilo_pkg::WORD_W-1];
      end
   endfunction : sext_word

   hilo_pkg::op_kind_type          kind;
   logic                           uses_pair;
   logic                           take;
   logic                           second_is_zero;
   logic                           cmove_kind;
   logic [hilo_pkg::REG_INDEX_W-1:0] dest_index;
   mul_state_type                  mul_state;
   logic [CNT_W-1:0]               mul_count;
   logic signed [PROD_W-1:0]       product;
   logic                           mul_done;
   logic [DATA_W-1:0]              top_word;
   logic [DATA_W-1:0]              bottom_word;
   logic                           result_unread;
   logic                           wb_valid;
   logic [hilo_pkg::REG_INDEX_W-1:0] wb_index;
   logic [DATA_W-1:0]              wb_data;
   logic                           reserved_instr;

   assign kind           = hilo_pkg::decode_op(link.instr);
   assign dest_index     = link.instr[hilo_pkg::RD_HI:hilo_pkg::RD_LO];
   assign second_is_zero = (link.second_value == '0);
   assign cmove_kind     = (kind == hilo_pkg::op_move_nonzero) ||
                           (kind == hilo_pkg::op_move_zero);
   assign uses_pair      = (kind == hilo_pkg::op_from_top) ||
                           (kind == hilo_pkg::op_from_bottom) ||
                           (kind == hilo_pkg::op_to_top) ||
                           (kind == hilo_pkg::op_to_bottom) ||
                           (kind == hilo_pkg::op_product);

   // Any touch of the pair waits out a running multiply; other work flows past
   assign link.issue_ready = !(mul_state == mul_run && uses_pair);
   assign take             = link.issue_valid && link.issue_ready;
   assign mul_done         = (mul_state == mul_run) && (mul_count == '0);

   // Multiply sequencer
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         mul_state <= mul_idle;
         mul_count <= '0;
      end else begin
         case (mul_state)
            mul_idle: begin
               if (take && kind == hilo_pkg::op_product) begin
                  mul_state <= mul_run;
                  mul_count <= CNT_LAST;
               end
            end
            mul_run: begin
               if (mul_count == '0)
                  mul_state <= mul_idle;
               else
                  mul_count <= mul_count - CNT_W'(1);
            end
            default: mul_state <= mul_idle;
         endcase
      end
   end

   // Operands are the low words; upper bits are assumed to be sign copies
   always_ff @(posedge clk_in) begin
      if (srst_in)
         product <= '0;
      else if (take && kind == hilo_pkg::op_product)
         product <= $signed(link.first_value[hilo_pkg::WORD_W-1:0]) *
                    $signed(link.second_value[hilo_pkg::WORD_W-1:0]);
   end

   // No overflow path exists: the product never flags anything.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         top_word    <= '0;
         bottom_word <= '0;
      end else if (mul_done) begin
         top_word    <= sext_word(product[PROD_W-1:hilo_pkg::WORD_W]);
         bottom_word <= sext_word(product[hilo_pkg::WORD_W-1:0]);
      end else if (take && kind == hilo_pkg::op_to_top) begin
         // The bottom word is simply kept, one legal choice for a spoiled half
         top_word <= link.first_value;
      end else if (take && kind == hilo_pkg::op_to_bottom) begin
         bottom_word <= link.first_value;
      end
   end

   // Tracks a computed result not yet copied out or overwritten by a word load
   always_ff @(posedge clk_in) begin
      if (srst_in)
         result_unread <= 1'b0;
      else if (mul_done)
         result_unread <= 1'b1;
      else if (take && (kind == hilo_pkg::op_from_top || kind == hilo_pkg::op_from_bottom))
         result_unread <= 1'b0;
      else if (take && (kind == hilo_pkg::op_to_top || kind == hilo_pkg::op_to_bottom))
         result_unread <= 1'b0;
   end

   // Write-back toward the general register file
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wb_valid <= 1'b0;
         wb_index <= '0;
         wb_data  <= '0;
      end else begin
         wb_valid <= 1'b0;
         if (take) begin
            case (kind)
               hilo_pkg::op_from_top: begin
                  wb_valid <= 1'b1;
                  wb_index <= dest_index;
                  wb_data  <= top_word;
               end
               hilo_pkg::op_from_bottom: begin
                  wb_valid <= 1'b1;
                  wb_index <= dest_index;
                  wb_data  <= bottom_word;
               end
               hilo_pkg::op_move_nonzero: begin
                  if (link.cmove_enable && !second_is_zero) begin
                     wb_valid <= 1'b1;
                     wb_index <= dest_index;
                     wb_data  <= link.first_value;
                  end
               end
               hilo_pkg::op_move_zero: begin
                  if (link.cmove_enable && second_is_zero) begin
                     wb_valid <= 1'b1;
                     wb_index <= dest_index;
                     wb_data  <= link.first_value;
                  end
               end
               default: wb_valid <= 1'b0;
            endcase
         end
      end
   end

   // Unsupported level: the move is dropped and flagged instead
   always_ff @(posedge clk_in) begin
      if (srst_in)
         reserved_instr <= 1'b0;
      else
         reserved_instr <= take && cmove_kind && !link.cmove_enable;
   end

   assign link.wb_valid       = wb_valid;
   assign link.wb_index       = wb_index;
   assign link.wb_data        = wb_data;
   assign link.reserved_instr = reserved_instr;
   assign top_word_out        = top_word;
   assign bottom_word_out     = bottom_word;
   assign busy_out            = (mul_state == mul_run);
   assign result_unread_out   = result_unread;

endmodule : hilo_multiply_move_unit

/* hilo_pkg.sv */
// Shared constants, operation kinds and decoding for the product register unit.
// Assumes both ends run on one 40 MHz clock with a synchronous active-high reset.
package hilo_pkg;

   localparam int unsigned INSTR_W      = 32;
   localparam int unsigned WORD_W       = 32;
   localparam int unsigned REG_INDEX_W  = 5;
   localparam int unsigned REG_COUNT    = 32;
   localparam int unsigned MUL_CYCLES   = 4;

   localparam logic [5:0] PRIMARY_OP    = 6'h00;
   localparam logic [5:0] FN_FROM_TOP   = 6'h10;
   localparam logic [5:0] FN_TO_TOP     = 6'h11;
   localparam logic [5:0] FN_FROM_BOT   = 6'h12;
   localparam logic [5:0] FN_TO_BOT     = 6'h13;
   localparam logic [5:0] FN_PRODUCT    = 6'h18;
   localparam logic [5:0] FN_MOVE_ZERO  = 6'h0a;
   localparam logic [5:0] FN_MOVE_NZERO = 6'h0b;

   // Field positions
   localparam int unsigned OP_HI   = 31;
   localparam int unsigned OP_LO   = 26;
   localparam int unsigned RS_HI   = 25;
   localparam int unsigned RS_LO   = 21;
   localparam int unsigned RT_HI   = 20;
   localparam int unsigned RT_LO   = 16;
   localparam int unsigned RD_HI   = 15;
   localparam int unsigned RD_LO   = 11;
   localparam int unsigned SA_HI   = 10;
   localparam int unsigned SA_LO   = 6;
   localparam int unsigned FN_HI   = 5;
   localparam int unsigned FN_LO   = 0;

   typedef enum logic [3:0] {
      op_none,
      op_from_top,
      op_from_bottom,
      op_to_top,
      op_to_bottom,
      op_product,
      op_move_nonzero,
      op_move_zero
   } op_kind_type;

   function automatic op_kind_type decode_op(input logic [INSTR_W-1:0] instr);
      logic       special;
      logic [5:0] fn;
      logic       zero_rs_rt;
      logic       zero_rt_sa;
      logic       zero_rd_sa;
      logic       zero_sa;
      special    = (instr[OP_HI:OP_LO] == PRIMARY_OP);
      fn         = instr[FN_HI:FN_LO];
      zero_rs_rt = (instr[RS_HI:RT_LO] == '0);
      zero_rt_sa = (instr[RT_HI:SA_LO] == '0);
      zero_rd_sa = (instr[RD_HI:SA_LO] == '0);
      zero_sa    = (instr[SA_HI:SA_LO] == '0);
      decode_op  = op_none;
      if (special) begin
         if (fn == FN_FROM_TOP && zero_rs_rt && zero_sa)
            decode_op = op_from_top;
         else if (fn == FN_FROM_BOT && zero_rs_rt && zero_sa)
            decode_op = op_from_bottom;
         else if (fn == FN_TO_TOP && zero_rt_sa)
            decode_op = op_to_top;
         else if (fn == FN_TO_BOT && zero_rt_sa)
            decode_op = op_to_bottom;
         else if (fn == FN_PRODUCT && zero_rd_sa)
            decode_op = op_product;
         else if (fn == FN_MOVE_NZERO && zero_sa)
            decode_op = op_move_nonzero;
         else if (fn == FN_MOVE_ZERO && zero_sa)
            decode_op = op_move_zero;
      end
   endfunction : decode_op

endpackage : hilo_pkg

/* hilo_link_if.sv */
// Link between the pipeline end and the product register unit.
// Assumes one clock shared by both ends; no clocking block.
`timescale 1ns/1ps
interface hilo_link_if #(
   parameter int unsigned DATA_W = hilo_pkg::WORD_W
);
   logic                                issue_valid;
   logic                                issue_ready;
   logic [hilo_pkg::INSTR_W-1:0]        instr;
   logic [DATA_W-1:0]                   first_value;
   logic [DATA_W-1:0]                   second_value;
   logic                                cmove_enable;
   logic                                wb_valid;
   logic [hilo_pkg::REG_INDEX_W-1:0]    wb_index;
   logic [DATA_W-1:0]                   wb_data;
   logic                                reserved_instr;

   modport unit (
      input  issue_valid, instr, first_value, second_value, cmove_enable,
      output issue_ready, wb_valid, wb_index, wb_data, reserved_instr
   );

   modport pipe (
      output issue_valid, instr, first_value, second_value, cmove_enable,
      input  issue_ready, wb_valid, wb_index, wb_data, reserved_instr
   );
endinterface : hilo_link_if

/* hilo_pipe_end.sv */
// Pipeline end: general register file, operand fetch and issue spacing checks.
// Assumes the unit answers on the same clock over hilo_link_if.
`timescale 1ns/1ps
module hilo_pipe_end #(
   parameter int unsigned DATA_W = hilo_pkg::WORD_W
) (
   input  wire logic                              clk_in,
   input  wire logic                              srst_in,
   hilo_link_if.pipe                              link,
   input  wire logic                              instr_valid_in,
   input  wire logic [hilo_pkg::INSTR_W-1:0]      instr_in,
   output logic                                   instr_ready_out,
   input  wire logic                              cmove_enable_in,
   input  wire logic [hilo_pkg::REG_INDEX_W-1:0]  peek_index_in,
   output logic [DATA_W-1:0]                      peek_data_out,
   output logic                                   spacing_fault_out,
   output logic                                   operand_fault_out,
   output logic                                   reserved_instr_out
);

   logic [DATA_W-1:0]      regs [hilo_pkg::REG_COUNT];
   hilo_pkg::op_kind_type  kind;
   hilo_pkg::op_kind_type  hist [2];
   logic                   take;
   logic [DATA_W-1:0]      first_value;
   logic [DATA_W-1:0]      second_value;
   logic                   spacing_fault;
   logic                   operand_fault;
   logic                   reserved_instr;
   logic                   recent_from_top;
   logic                   recent_from_bottom;

   // Register read with bypass of the write landing this cycle
   function automatic logic [DATA_W-1:0] fetch(input logic [hilo_pkg::REG_INDEX_W-1:0] idx);
      if (idx == '0)
         fetch = '0;
      else if (link.wb_valid && link.wb_index == idx)
         fetch = link.wb_data;
      else
         fetch = regs[idx];
   endfunction : fetch

   function automatic logic not_word(input logic [DATA_W-1:0] v);
      not_word = 1'b0;
      for (int i = hilo_pkg::WORD_W; i < DATA_W; i++) begin
         if (v[i] != v[hilo_pkg::WORD_W-1])
            not_word = 1'b1;
      end
   endfunction : not_word

   assign kind         = hilo_pkg::decode_op(instr_in);
   // Not an assign: fetch reads the file and the bypass
   always_comb begin
      first_value  = fetch(instr_in[hilo_pkg::RS_HI:hilo_pkg::RS_LO]);
      second_value = fetch(instr_in[hilo_pkg::RT_HI:hilo_pkg::RT_LO]);
   end
   assign take         = instr_valid_in && link.issue_ready;

   assign link.issue_valid  = instr_valid_in;
   assign link.instr        = instr_in;
   assign link.first_value  = first_value;
   assign link.second_value = second_value;
   assign link.cmove_enable = cmove_enable_in;
   assign instr_ready_out   = link.issue_ready;

   assign recent_from_top    = (hist[0] == hilo_pkg::op_from_top) ||
                               (hist[1] == hilo_pkg::op_from_top);
   assign recent_from_bottom = (hist[0] == hilo_pkg::op_from_bottom) ||
                               (hist[1] == hilo_pkg::op_from_bottom);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         for (int i = 0; i < hilo_pkg::REG_COUNT; i++)
            regs[i] <= '0;
      end else if (link.wb_valid && link.wb_index != '0) begin
         regs[link.wb_index] <= link.wb_data;
      end
   end

   // Last two issued operations, for spacing checks
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         hist[0] <= hilo_pkg::op_none;
         hist[1] <= hilo_pkg::op_none;
      end else if (take) begin
         hist[0] <= kind;
         hist[1] <= hist[0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         spacing_fault <= 1'b0;
         operand_fault <= 1'b0;
      end else begin
         spacing_fault <= take && (
            (recent_from_top && kind == hilo_pkg::op_to_top) ||
            (recent_from_bottom && kind == hilo_pkg::op_to_bottom) ||
            ((recent_from_top || recent_from_bottom) &&
             kind == hilo_pkg::op_product));
         operand_fault <= take && kind == hilo_pkg::op_product &&
                          (not_word(first_value) || not_word(second_value));
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         reserved_instr <= 1'b0;
         peek_data_out  <= '0;
      end else begin
         reserved_instr <= link.reserved_instr;
         peek_data_out  <= regs[peek_index_in];
      end
   end

   assign spacing_fault_out  = spacing_fault;
   assign operand_fault_out  = operand_fault;
   assign reserved_instr_out = reserved_instr;

endmodule : hilo_pipe_end

/* hilo_link_properties.sv */
// Concurrent checks on the link between the pipeline end and the product unit.
// Assumes one clock, synchronous active-high reset, signals taken from hilo_link_if.
`timescale 1ns/1ps
module hilo_link_properties #(
   parameter int unsigned DATA_W     = hilo_pkg::WORD_W,
   parameter int unsigned MUL_CYCLES = hilo_pkg::MUL_CYCLES
) (
   input wire logic              clk_in,
   input wire logic              srst_in,
   input wire logic              issue_valid,
   input wire logic              issue_ready,
   input wire logic [31:0]       instr,
   input wire logic [DATA_W-1:0] first_value,
   input wire logic [DATA_W-1:0] second_value,
   input wire logic              cmove_enable,
   input wire logic              wb_valid,
   input wire logic [4:0]        wb_index,
   input wire logic [DATA_W-1:0] wb_data,
   input wire logic              reserved_instr
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   logic       taken;
   logic       special;
   logic [5:0] fn;
   logic [4:0] dest;
   logic       copy_op;
   logic       to_op;
   logic       prod_op;
   logic       cmove_op;
   logic       cmove_true;
   logic       wb_cause;
   logic       rsv_cause;
   logic [7:0] busy_left;

   assign taken      = issue_valid && issue_ready;
   assign fn         = instr[5:0];
   assign dest       = instr[15:11];
   assign special    = instr[31:26] == 6'h00;
   assign copy_op    = special && instr[25:16] == 10'h000 && instr[10:6] == 5'h00
                       && (fn == 6'h10 || fn == 6'h12);
   assign to_op      = special && instr[20:6] == 15'h0000 && (fn == 6'h11 || fn == 6'h13);
   assign prod_op    = special && instr[15:6] == 10'h000 && fn == 6'h18;
   assign cmove_op   = special && instr[10:6] == 5'h00 && (fn == 6'h0a || fn == 6'h0b);
   assign cmove_true = (fn == 6'h0b) ? (second_value != '0) : (second_value == '0);
   assign wb_cause   = taken && (copy_op || (cmove_op && cmove_enable && cmove_true));
   assign rsv_cause  = taken && cmove_op && !cmove_enable;

   // Mirrors the multiply run so stalls can be judged without the unit's busy flag
   always_ff @(posedge clk_in) begin
      if (srst_in)
         busy_left <= 8'h00;
      else if (taken && prod_op)
         busy_left <= 8'(MUL_CYCLES);
      else if (busy_left != 8'h00)
         busy_left <= busy_left - 8'h01;
   end

   chk_copy_answer: assert property (taken && copy_op |=> wb_valid && wb_index == $past(dest))
      else $error("copy from product word gave no write-back");
   chk_cmove_result: assert property (taken && cmove_op && cmove_enable |=>
      wb_valid == $past(cmove_true)
      && (!wb_valid || (wb_data == $past(first_value) && wb_index == $past(dest))))
      else $error("conditional move result wrong");
   chk_cmove_reserved: assert property (rsv_cause |=> reserved_instr && !wb_valid)
      else $error("disabled conditional move not refused");
   chk_reserved_cause: assert property (reserved_instr |-> $past(rsv_cause))
      else $error("reserved pulse without cause");
   chk_load_quiet: assert property (taken && (to_op || prod_op) |=> !wb_valid && !reserved_instr)
      else $error("word load or multiply answered on the link");
   chk_wb_cause: assert property (wb_valid |-> $past(wb_cause))
      else $error("write-back without cause");
   chk_pair_stall: assert property (busy_left != 8'h00 && issue_valid
      && (copy_op || to_op || prod_op) |-> !issue_ready)
      else $error("pair access accepted during multiply");
   chk_ready_idle: assert property (busy_left == 8'h00 |-> issue_ready)
      else $error("unit refused while idle");
   chk_stall_bound: assert property (issue_valid && copy_op && !issue_ready
      |-> ##[1:8] issue_ready)
      else $error("copy stall too long");

   cover property (taken && prod_op);
   cover property (issue_valid && copy_op && !issue_ready);
   cover property (reserved_instr);
   cover property (wb_valid && wb_index != 5'h00);
endmodule : hilo_link_properties

/* hilo_multiply_move_unit_tb.sv */
// Self-checking bench: unit and pipeline end joined, plus a second unit driven directly.
// Assumes the second link carries operands the register file cannot produce from reset.
`timescale 1ns/1ps
module hilo_multiply_move_unit_tb;
   localparam int unsigned MULS = 4;

   logic        clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        instr_valid;
   logic [31:0] instr;
   logic        cmove_enable;
   logic        instr_ready;
   logic        spacing_fault;
   logic        operand_fault;
   logic        reserved_out;
   logic [31:0] top2;
   logic [31:0] bottom2;
   logic        busy2;
   logic        unread2;
   logic [31:0] p_top;
   logic [63:0] p;
   logic [31:0] pa [4] = '{32'hffff_fffd, 32'h8000_0000, 32'h7fff_ffff, 32'h8000_0000};
   logic [31:0] pb [4] = '{32'h0000_0007, 32'h8000_0000, 32'h7fff_ffff, 32'h7fff_ffff};
   int          n_errors = 0;
   int          checks = 0;
   int          w;

   always #12.5 clk_in = ~clk_in;

   hilo_link_if link ();
   hilo_link_if link2 ();

   hilo_multiply_move_unit #(.MUL_CYCLES(MULS)) u_hilo_multiply_move_unit (
      .clk_in(clk_in), .srst_in(srst_in), .link(link), .top_word_out(),
      .bottom_word_out(), .busy_out(), .result_unread_out());
   hilo_multiply_move_unit #(.MUL_CYCLES(MULS)) u_hilo_multiply_move_unit_direct (
      .clk_in(clk_in), .srst_in(srst_in), .link(link2), .top_word_out(top2),
      .bottom_word_out(bottom2), .busy_out(busy2), .result_unread_out(unread2));
   hilo_pipe_end u_hilo_pipe_end (
      .clk_in(clk_in), .srst_in(srst_in), .link(link), .instr_valid_in(instr_valid),
      .instr_in(instr), .instr_ready_out(instr_ready), .cmove_enable_in(cmove_enable),
      .peek_index_in(5'h00), .peek_data_out(), .spacing_fault_out(spacing_fault),
      .operand_fault_out(operand_fault), .reserved_instr_out(reserved_out));
   hilo_link_properties #(.MUL_CYCLES(MULS)) u_hilo_link_properties (
      .clk_in(clk_in), .srst_in(srst_in), .issue_valid(link.issue_valid),
      .issue_ready(link.issue_ready), .instr(link.instr), .first_value(link.first_value),
      .second_value(link.second_value), .cmove_enable(link.cmove_enable),
      .wb_valid(link.wb_valid), .wb_index(link.wb_index), .wb_data(link.wb_data),
      .reserved_instr(link.reserved_instr));

   function automatic logic [31:0] enc(input logic [5:0] fn, input int rs, rt, rd, sa);
      return {6'h00, rs[4:0], rt[4:0], rd[4:0], sa[4:0], fn};
   endfunction : enc

   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   // Held until ready is seen; released instr and operand lines carry inverted values, cmove_enable keeps its value
   task automatic issue_direct(input logic [31:0] ins, a, b, input logic en, output int n);
      @(posedge clk_in);
      link2.issue_valid  <= 1'b1;
      link2.instr        <= ins;
      link2.first_value  <= a;
      link2.second_value <= b;
      link2.cmove_enable <= en;
      n = 0;
      @(posedge clk_in);
      while (link2.issue_ready !== 1'b1) begin
         n++;
         @(posedge clk_in);
      end
      link2.issue_valid  <= 1'b0;
      link2.instr        <= ~ins;
      link2.first_value  <= ~a;
      link2.second_value <= ~b;
   endtask : issue_direct

   task automatic expect_wb(input logic v, input logic [4:0] idx, input logic [31:0] d,
                            input logic rsv);
      @(posedge clk_in);
      check("wb_valid", link2.wb_valid, v);
      check("reserved_instr", link2.reserved_instr, rsv);
      if (v) begin
         check("wb_index", link2.wb_index, idx);
         check("wb_data", link2.wb_data, d);
      end
   endtask : expect_wb

   task automatic pipe_step(input logic [31:0] ins, input logic fault);
      @(posedge clk_in);
      instr_valid <= 1'b1;
      instr       <= ins;
      @(posedge clk_in);
      while (instr_ready !== 1'b1) begin
         @(posedge clk_in);
      end
      instr_valid <= 1'b0;
      @(posedge clk_in);
      check("spacing fault", spacing_fault, fault);
   endtask : pipe_step

   initial begin
      repeat (2000) @(posedge clk_in);
      n_errors++;
      finish_test();
   end

   initial begin
      instr_valid        = 1'b0;
      instr              = 32'h0000_0000;
      cmove_enable       = 1'b1;
      link2.issue_valid  = 1'b0;
      link2.instr        = 32'h0000_0000;
      link2.first_value  = 32'h0000_0000;
      link2.second_value = 32'h0000_0000;
      link2.cmove_enable = 1'b1;
      repeat (4) @(posedge clk_in);
      srst_in <= 1'b0;
      issue_direct(enc(hilo_pkg::FN_TO_TOP, 5'h03, 0, 0, 0), 32'h1234_5678, 0, 1'b1, w);
      expect_wb(1'b0, 0, 0, 1'b0);
      issue_direct(enc(hilo_pkg::FN_FROM_TOP, 0, 0, 5'h09, 0), 0, 0, 1'b1, w);
      expect_wb(1'b1, 5'h09, 32'h1234_5678, 1'b0);
      issue_direct(enc(hilo_pkg::FN_TO_BOT, 5'h03, 0, 0, 0), 32'h9abc_def0, 0, 1'b1, w);
      expect_wb(1'b0, 0, 0, 1'b0);
      issue_direct(enc(hilo_pkg::FN_FROM_BOT, 0, 0, 5'h0a, 0), 0, 0, 1'b1, w);
      expect_wb(1'b1, 5'h0a, 32'h9abc_def0, 1'b0);
      // Nonzero shift field makes the copy malformed
      issue_direct(enc(hilo_pkg::FN_FROM_TOP, 0, 0, 5'h09, 5'h01), 0, 0, 1'b1, w);
      expect_wb(1'b0, 0, 0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         repeat (2) issue_direct(32'h0000_0000, 0, 0, 1'b1, w);
         p = $signed({{32{pa[i][31]}}, pa[i]}) * $signed({{32{pb[i][31]}}, pb[i]});
         p_top = p[63:32];
         issue_direct(enc(hilo_pkg::FN_PRODUCT, 5'h01, 5'h02, 0, 0), pa[i], pb[i], 1'b1, w);
         issue_direct(enc(hilo_pkg::FN_FROM_BOT, 0, 0, 5'h04, 0), 0, 0, 1'b1, w);
         check("stall cycles", w, MULS - 1);
         expect_wb(1'b1, 5'h04, p[31:0], 1'b0);
         issue_direct(enc(hilo_pkg::FN_FROM_TOP, 0, 0, 5'h05, 0), 0, 0, 1'b1, w);
         expect_wb(1'b1, 5'h05, p_top, 1'b0);
      end
      check("top word", top2, p_top);
      repeat (2) issue_direct(32'h0000_0000, 0, 0, 1'b1, w);
      issue_direct(enc(hilo_pkg::FN_PRODUCT, 1, 2, 0, 0), pa[3], pb[3], 1'b1, w);
      @(posedge clk_in);
      check("busy", busy2, 1'b1);
      repeat (MULS) @(posedge clk_in);
      check("unread", unread2, 1'b1);
      issue_direct(enc(hilo_pkg::FN_TO_TOP, 3, 0, 0, 0), 32'h0000_0001, 0, 1'b1, w);
      expect_wb(1'b0, 0, 0, 1'b0);
      check("unread", unread2, 1'b0);
      check("bottom word", bottom2, p[31:0]);
      for (int k = 0; k < 8; k++) begin
         issue_direct(enc(k[1] ? hilo_pkg::FN_MOVE_NZERO : hilo_pkg::FN_MOVE_ZERO, 5'h01,
                          5'h02, 5'h07, 0), 32'h0bad_f00d, k[0] ? 32'h5 : 32'h0, k[2], w);
         expect_wb(k[2] && (k[1] == k[0]), 5'h07, 32'h0bad_f00d, !k[2]);
      end
      pipe_step(enc(hilo_pkg::FN_PRODUCT, 5'h01, 5'h02, 0, 0), 1'b0);
      pipe_step(enc(hilo_pkg::FN_FROM_TOP, 0, 0, 5'h03, 0), 1'b0);
      pipe_step(enc(hilo_pkg::FN_TO_TOP, 5'h04, 0, 0, 0), 1'b1);
      pipe_step(enc(hilo_pkg::FN_FROM_BOT, 0, 0, 5'h03, 0), 1'b0);
      pipe_step(enc(hilo_pkg::FN_PRODUCT, 5'h01, 5'h02, 0, 0), 1'b1);
      repeat (2) pipe_step(32'h0000_0000, 1'b0);
      pipe_step(enc(hilo_pkg::FN_TO_BOT, 5'h04, 0, 0, 0), 1'b0);
      pipe_step(enc(hilo_pkg::FN_FROM_TOP, 0, 0, 5'h03, 0), 1'b0);
      pipe_step(32'h0000_0000, 1'b0);
      pipe_step(enc(hilo_pkg::FN_TO_TOP, 5'h04, 0, 0, 0), 1'b1);
      cmove_enable <= 1'b0;
      pipe_step(enc(hilo_pkg::FN_MOVE_ZERO, 5'h01, 5'h02, 5'h03, 0), 1'b0);
      @(posedge clk_in);
      check("reserved out", reserved_out, 1'b1);
      cmove_enable <= 1'b1;
      pipe_step(enc(hilo_pkg::FN_MOVE_ZERO, 5'h01, 5'h02, 5'h03, 0), 1'b0);
      pipe_step(enc(hilo_pkg::FN_MOVE_NZERO, 5'h01, 5'h02, 5'h03, 0), 1'b0);
      check("operand fault", operand_fault, 1'b0);
      finish_test();
   end
endmodule : hilo_multiply_move_unit_tb
